/* dv/ccs_command_status_chk.sv */
// Concurrent checks on the ports of the CAN command and status block.
`timescale 1ns/10ps
`include "ccs_defs.vh"
module ccs_command_status_chk
(
	input wire        clock_in, reset_in, wr_in, rd_in, silent_mode_in,
	input wire [11:0] addr_in,
	input wire [7:0]  wdata_in, rdata_out, tx_err_count_in, rx_err_count_in, warn_limit_in,
	input wire        core_bus_off_in, core_tx_busy_in, core_tx_started_in, core_tx_success_in,
	input wire        core_intermission_first_in, rx_msg_store_in, rx_no_space_in,
	input wire        tx_request_out, tx_done_flag_out, tx_buffer_free_flag_out, tx_ind_out,
	input wire        rx_overflow_flag_out, overload_go_out, bus_off_flag_out,
	input wire        error_warn_flag_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	wire cw = wr_in && addr_in == `CCS_CMD_ADDR && !silent_mode_in;
	wire wl = tx_err_count_in >= warn_limit_in || rx_err_count_in >= warn_limit_in;
	property p_send; cw && wdata_in[0] && tx_buffer_free_flag_out && !core_tx_busy_in
		|=> tx_request_out && !tx_done_flag_out && !tx_buffer_free_flag_out; endproperty
	a_send: assert property (p_send) else $error("send not taken");
	property p_hold; !tx_done_flag_out && !core_tx_success_in |=> !tx_done_flag_out; endproperty
	a_hold: assert property (p_hold) else $error("done rose early");
	property p_ok; core_tx_success_in && !tx_buffer_free_flag_out
		|=> tx_done_flag_out && tx_buffer_free_flag_out && tx_ind_out; endproperty
	a_ok: assert property (p_ok) else $error("success lost");
	property p_abort; tx_request_out && cw && wdata_in[1] && !core_tx_started_in
		|=> !tx_request_out && tx_buffer_free_flag_out && !tx_done_flag_out; endproperty
	a_abort: assert property (p_abort) else $error("abort missed");
	property p_ovr; rx_msg_store_in && rx_no_space_in |=> rx_overflow_flag_out; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun missed");
	property p_clr; cw && wdata_in[3] && !rx_msg_store_in |=> !rx_overflow_flag_out; endproperty
	a_clr: assert property (p_clr) else $error("overrun kept");
	property p_mir; 1'b1 |=> bus_off_flag_out == $past(core_bus_off_in)
		&& error_warn_flag_out == $past(wl); endproperty
	a_mir: assert property (p_mir) else $error("flag mismatch");
	property p_crd; rd_in && addr_in == `CCS_CMD_ADDR |=> rdata_out == 8'h00; endproperty
	a_crd: assert property (p_crd) else $error("command read");
	property p_olf; overload_go_out |-> $past(core_intermission_first_in); endproperty
	a_olf: assert property (p_olf) else $error("overload timing");
	property p_sil; silent_mode_in && wr_in && addr_in == `CCS_CMD_ADDR |=> !tx_request_out;
	endproperty
	a_sil: assert property (p_sil) else $error("silent write");
endmodule
bind ccs_command_status ccs_command_status_chk ccs_command_status_chk_i (.*);

/* dv/ccs_command_status_tb.sv */
// Self-checking bench for the CAN command and status block.
`timescale 1ns/10ps
`include "ccs_defs.vh"
module ccs_command_status_tb;
	logic        clock_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
	logic        silent_mode_in = 1'b0, core_bus_off_in = 1'b0, core_rx_busy_in = 1'b0;
	logic [11:0] addr_in = 12'h000;
	logic [7:0]  wdata_in = 8'h00, tx_err_count_in = 8'h00, rx_err_count_in = 8'h00;
	logic [7:0]  warn_limit_in = 8'h60, txbuf_wdata_in = 8'h00, rdata_out, txbuf_wdata_out, r;
	logic        core_intermission_first_in = 1'b0, rx_msg_store_in = 1'b0;
	logic        rx_no_space_in = 1'b0, rx_head_relay_in = 1'b0, txbuf_wr_in = 1'b0;
	logic        core_tx_busy_in, core_tx_started_in, core_tx_success_in, txbuf_wr_out;
	logic        tx_request_out, tx_loopback_out, overload_go_out, relay_go_out, rx_release_out;
	logic        rx_irq_clear_out, rx_ind_out, tx_ind_out, bus_off_flag_out, error_warn_flag_out;
	logic        tx_active_flag_out, rx_active_flag_out, tx_done_flag_out, tx_buffer_free_flag_out;
	logic        rx_overflow_flag_out, rx_msg_pending_flag_out;
	logic [3:0]  lag = 4'h0;
	integer      seed = 83767, fail_count = 0, n_tests = 0, i, n, k;
	ccs_command_status #(.RXQ_DEPTH(8)) ccs_command_status_i (.*);
	ccs_core_model ccs_core_model_i (.clock_in(clock_in), .reset_in(reset_in),
		.req_in(tx_request_out), .lag_in(lag), .started_out(core_tx_started_in),
		.busy_out(core_tx_busy_in), .success_out(core_tx_success_in));
	always #25 clock_in = ~clock_in;
	function warn(input [7:0] t, input [7:0] x, input [7:0] l);
		warn = t >= l || x >= l;
	endfunction
	task chk(input [15:0] seen, input [15:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		@(posedge clock_in);
		wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
		@(posedge clock_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task rd(input [11:0] a);
		@(posedge clock_in);
		rd_in <= 1'b1; addr_in <= a;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 r = rdata_out;
	endtask
	task store(input ns);
		@(posedge clock_in);
		rx_msg_store_in <= 1'b1; rx_no_space_in <= ns;
		@(posedge clock_in);
		rx_msg_store_in <= 1'b0;
		#1;
	endtask
	task bw(input [7:0] d, input e);
		@(posedge clock_in);
		txbuf_wr_in <= 1'b1; txbuf_wdata_in <= d;
		@(posedge clock_in);
		txbuf_wr_in <= 1'b0;
		#1 chk({txbuf_wr_out, txbuf_wdata_out & {8{e}}}, {e, d & {8{e}}});
	endtask
	// Waits a bounded time for a transmit start (s low) or a transmit indication (s high).
	task wt(input s);
		k = 0;
		while ((s ? tx_ind_out : core_tx_started_in) !== 1'b1 && k < 99)
		begin
			@(posedge clock_in);
			#1 k = k + 1;
		end
		chk(k < 99, 1'b1);
	endtask
	task complete_run;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#(50 * 20000);
		fail_count = fail_count + 1;
		complete_run;
	end
	initial
	begin
		repeat (4) @(posedge clock_in);
		reset_in <= 1'b0;
		rd(`CCS_STATE_ADDR); chk(r, 8'h0C);
		rd(`CCS_CMD_ADDR); chk(r, 8'h00);
		rd(12'h7FF); chk(r, 8'h00);
		// Plain send, loopback send, and an abort that arrives after the start.
		for (i = 0; i < 3; i = i + 1)
		begin
			lag <= $random(seed);
			wr(`CCS_CMD_ADDR, i == 1 ? 8'h10 : 8'h01);
			chk({tx_request_out, tx_loopback_out, tx_done_flag_out}, {1'b1, i == 1, 1'b0});
			if (i == 2) wt(1'b0);
			if (i == 2) wr(`CCS_CMD_ADDR, 8'h02);
			if (i == 2) chk({tx_active_flag_out, tx_request_out}, 2'h2);
			wt(1'b1);
			chk({tx_done_flag_out, tx_buffer_free_flag_out, tx_active_flag_out}, 3'h6);
		end
		lag <= 4'hF;
		wr(`CCS_CMD_ADDR, 8'h01);
		bw($random(seed), 1'b0);
		wr(`CCS_CMD_ADDR, 8'h02);
		chk({tx_request_out, tx_buffer_free_flag_out, tx_done_flag_out}, 3'h2);
		bw($random(seed), 1'b1);
		wr(`CCS_CMD_ADDR, 8'h80); chk(tx_request_out, 1'b0);
		// An unstarted request must be withdrawn when silent mode is entered.
		wr(`CCS_CMD_ADDR, 8'h01); chk(tx_request_out, 1'b1);
		silent_mode_in <= 1'b1;
		wr(`CCS_CMD_ADDR, 8'h01);
		chk({tx_request_out, tx_buffer_free_flag_out, tx_done_flag_out}, 3'h2);
		silent_mode_in <= 1'b0;
		n = 1 + ($random(seed) & 7);
		for (i = 0; i < n; i = i + 1)
		begin
			store(1'b0); chk({rx_ind_out, rx_msg_pending_flag_out}, 2'h3);
		end
		store(n != 8); chk(rx_overflow_flag_out, 1'b1);
		wr(`CCS_CMD_ADDR, 8'h08); chk(rx_overflow_flag_out, 1'b0);
		for (i = 0; i < n; i = i + 1)
		begin
			wr(`CCS_CMD_ADDR, 8'h04);
			chk({rx_release_out, rx_irq_clear_out, rx_msg_pending_flag_out}, {1'b1, i == n - 1, i != n - 1});
		end
		store(1'b0);
		rx_head_relay_in <= $random(seed);
		wr(`CCS_CMD_ADDR, 8'h44); chk(relay_go_out, rx_head_relay_in);
		wr(`CCS_CMD_ADDR, 8'h20); chk(overload_go_out, 1'b0);
		@(posedge clock_in); core_intermission_first_in <= 1'b1;
		@(posedge clock_in); core_intermission_first_in <= 1'b0;
		#1 chk(overload_go_out, 1'b1);
		for (i = 0; i < 8; i = i + 1)
		begin
			n = $random(seed);
			{core_bus_off_in, core_rx_busy_in} <= $random(seed);
			tx_err_count_in <= n; rx_err_count_in <= $random(seed);
			warn_limit_in <= i[0] ? n : n + 1;
			rd(`CCS_STATE_ADDR);
			chk(r[7:4], {core_bus_off_in, warn(tx_err_count_in, rx_err_count_in, warn_limit_in), 1'b0, core_rx_busy_in});
		end
		complete_run;
	end
endmodule

/* dv/ccs_core_model.sv */
// Protocol core stand-in that answers transmit requests after a chosen lag.
`timescale 1ns/10ps
module ccs_core_model
(
	input  wire       clock_in,
	input  wire       reset_in,
	input  wire       req_in,
	input  wire [3:0] lag_in,
	output reg        started_out,
	output reg        busy_out,
	output reg        success_out
);
	reg [4:0] cnt;
	always @(posedge clock_in)
	begin
		started_out <= 1'b0;
		success_out <= 1'b0;
		if (reset_in)
		begin
			busy_out <= 1'b0;
			cnt <= 5'h00;
		end
		else if (busy_out)
		begin
			cnt <= cnt + 5'h01;
			// A frame takes a fixed time once started, so an abort cannot cut it short.
			if (cnt == 5'h0C)
			begin
				busy_out <= 1'b0;
				success_out <= 1'b1;
			end
		end
		else if (!req_in)
			cnt <= 5'h00;
		else if (cnt == {1'b0, lag_in})
		begin
			started_out <= 1'b1;
			busy_out <= 1'b1;
			cnt <= 5'h00;
		end
		else
			cnt <= cnt + 5'h01;
	end
endmodule

/* hdl/ccs_command_status.v */
// Command and status registers of one CAN controller, facing the protocol core and receive queue.
//
// Contract
// RULE1 - Relay only with frame relay flag and command.
// RULE2 - Overload frame starts only at intermission's first bit.
// RULE3 - Loopback send transmits and receives, both indicated.
// RULE4 - Overflow clear command clears receive overrun flag.
// RULE5 - Slot release frees head message; empty clears interrupt.
// RULE6 - Abort cancels unstarted send, never one underway.
// RULE7 - Software checks done flag after buffer release.
// RULE8 - Send command starts transmitting the buffered message.
// RULE9 - Software cancels repeated send by abort or zero.
// RULE10 - Bus-off flag shows withdrawal; resets to zero.
// RULE11 - Warning flag when any counter reaches limit.
// RULE12 - Transmit activity flag follows sending; resets zero.
// RULE13 - Receive activity flag follows receiving; resets zero.
// RULE14 - Done flag resets one, zero while incomplete.
// RULE15 - Buffer free flag resets one, zero while locked.
// RULE16 - Overrun flag set when a message is lost.
// RULE17 - Pending flag shows messages in receive queue.
// RULE18 - Commands taken only operating; read zero; silent clears.
// RULE19 - Send or loopback drops done flag until success.
// RULE20 - Buffer writes while locked are silently dropped.
// RULE21 - Reserved command bit is ignored.
`timescale 1ns/10ps
`include "ccs_defs.vh"
module ccs_command_status
#(
	parameter RXQ_DEPTH = 8,
	parameter CNT_W     = 4
)
(
	input  wire                   clock_in,
	input  wire                   reset_in,
	input  wire [`CCS_ADDR_W-1:0] addr_in,
	input  wire [7:0]             wdata_in,
	input  wire                   wr_in,
	input  wire                   rd_in,
	output reg  [7:0]             rdata_out,
	input  wire                   silent_mode_in,
	input  wire                   core_bus_off_in,
	input  wire [7:0]             tx_err_count_in,
	input  wire [7:0]             rx_err_count_in,
	input  wire [7:0]             warn_limit_in,
	input  wire                   core_tx_busy_in,
	input  wire                   core_rx_busy_in,
	input  wire                   core_tx_started_in,
	input  wire                   core_tx_success_in,
	input  wire                   core_intermission_first_in,
	input  wire                   rx_msg_store_in,
	input  wire                   rx_no_space_in,
	input  wire                   rx_head_relay_in,
	input  wire                   txbuf_wr_in,
	input  wire [7:0]             txbuf_wdata_in,
	output reg                    txbuf_wr_out,
	output reg  [7:0]             txbuf_wdata_out,
	output reg                    tx_request_out,
	output reg                    tx_loopback_out,
	output reg                    overload_go_out,
	output reg                    relay_go_out,
	output reg                    rx_release_out,
	output reg                    rx_irq_clear_out,
	output reg                    rx_ind_out,
	output reg                    tx_ind_out,
	output reg                    bus_off_flag_out,
	output reg                    error_warn_flag_out,
	output reg                    tx_active_flag_out,
	output reg                    rx_active_flag_out,
	output wire                   tx_done_flag_out,
	output wire                   tx_buffer_free_flag_out,
	output wire                   rx_overflow_flag_out,
	output reg                    rx_msg_pending_flag_out
);

	// Transmit request sequencer, one-hot.
	localparam TX_IDLE = 3'b001;
	localparam TX_WAIT = 3'b010;
	localparam TX_RUN  = 3'b100;

	reg  [2:0]       tx_state;
	reg  [2:0]       next_tx_state;
	reg  [CNT_W-1:0] rx_count;
	reg  [CNT_W-1:0] next_rx_count;
	reg              overload_pending;

	wire             cmd_wr;
	wire             send_go_cmd;
	wire             abort_send_cmd;
	wire             rx_slot_free_cmd;
	wire             overflow_clear_cmd;
	wire             loopback_send_cmd;
	wire             overload_send_cmd;
	wire             relay_go_cmd;
	wire             tx_accept;
	wire             tx_abort;
	wire             rx_full;
	wire             rx_lost;
	wire             rx_kept;
	wire             rx_freed;
	wire [7:0]       state_reg;

	// Writes are only honoured in operating mode; silent mode drops them. [RULE18]
	assign cmd_wr             = wr_in && (addr_in == `CCS_CMD_ADDR) && !silent_mode_in;
	// Bit 7 is never decoded, so writing it has no effect. [RULE21]
	assign send_go_cmd        = cmd_wr && wdata_in[`CCS_CMD_SEND_GO];
	assign abort_send_cmd     = cmd_wr && wdata_in[`CCS_CMD_ABORT_SEND];
	assign rx_slot_free_cmd   = cmd_wr && wdata_in[`CCS_CMD_RX_SLOT_FREE];
	assign overflow_clear_cmd = cmd_wr && wdata_in[`CCS_CMD_OVF_CLEAR];
	assign loopback_send_cmd  = cmd_wr && wdata_in[`CCS_CMD_LOOPBACK_SEND];
	assign overload_send_cmd  = cmd_wr && wdata_in[`CCS_CMD_OVERLOAD_SEND];
	assign relay_go_cmd       = cmd_wr && wdata_in[`CCS_CMD_RELAY_GO];

	// A new request is only taken while nothing is queued or on the bus. [RULE8]
	assign tx_accept = (send_go_cmd || loopback_send_cmd) && (tx_state == TX_IDLE);
	// Start beats abort: once the core has begun, the frame must finish. [RULE6]
	assign tx_abort  = (tx_state == TX_WAIT) && !core_tx_started_in &&
		(abort_send_cmd || silent_mode_in);

	always @*
	begin
		next_tx_state = tx_state;
		case (tx_state)
			TX_IDLE:
				if (tx_accept)
					next_tx_state = TX_WAIT;
			TX_WAIT:
				if (core_tx_started_in)
					next_tx_state = TX_RUN;
				else if (tx_abort)
					next_tx_state = TX_IDLE;
			TX_RUN:
				if (core_tx_success_in)
					next_tx_state = TX_IDLE;
			default:
				next_tx_state = TX_IDLE;
		endcase
	end

	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			tx_state        <= TX_IDLE;
			tx_request_out  <= 1'b0;
			tx_loopback_out <= 1'b0;
			tx_ind_out      <= 1'b0;
		end
		else
		begin
			tx_state       <= next_tx_state;
			tx_request_out <= (next_tx_state == TX_WAIT); // [RULE8] [RULE6]
			if (tx_accept)
				tx_loopback_out <= loopback_send_cmd && !send_go_cmd; // [RULE3]
			else if (next_tx_state == TX_IDLE)
				tx_loopback_out <= 1'b0;
			// Loopback frames report transmit completion like any other. [RULE3]
			tx_ind_out <= core_tx_success_in && (tx_state == TX_RUN);
		end
	end

	// Done drops on each accepted request and rises only on success. [RULE14] [RULE19]
	ccs_flag
	#(
		.RESET_VAL (`CCS_RST_TX_DONE)
	)
	u_tx_done
	(
		.clock_in (clock_in),
		.reset_in (reset_in),
		.set_in   (core_tx_success_in && (tx_state == TX_RUN)),
		.clear_in (tx_accept),
		.flag_out (tx_done_flag_out)
	);

	// The buffer locks while a request waits or runs; abort releases it. [RULE15]
	ccs_flag
	#(
		.RESET_VAL (`CCS_RST_TX_BUF_FREE)
	)
	u_tx_buf_free
	(
		.clock_in (clock_in),
		.reset_in (reset_in),
		.set_in   ((core_tx_success_in && (tx_state == TX_RUN)) || tx_abort),
		.clear_in (tx_accept),
		.flag_out (tx_buffer_free_flag_out)
	);

	// Buffer writes are forwarded one cycle late and only while unlocked. [RULE20]
	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			txbuf_wr_out    <= 1'b0;
			txbuf_wdata_out <= 8'h00;
		end
		else
		begin
			txbuf_wr_out    <= txbuf_wr_in && tx_buffer_free_flag_out && !tx_accept; // [RULE20]
			txbuf_wdata_out <= txbuf_wdata_in;
		end
	end

	// Overload request waits for the first intermission bit and nothing else. [RULE2]
	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			overload_pending <= 1'b0;
			overload_go_out  <= 1'b0;
		end
		else
		begin
			overload_go_out <= overload_pending && core_intermission_first_in; // [RULE2]
			if (silent_mode_in)
				overload_pending <= 1'b0;
			else if (overload_send_cmd)
				overload_pending <= 1'b1;
			else if (core_intermission_first_in)
				overload_pending <= 1'b0;
		end
	end

	// Receive queue bookkeeping counts whole messages held.
	assign rx_full  = (rx_count == RXQ_DEPTH[CNT_W-1:0]);
	assign rx_lost  = rx_msg_store_in && (rx_no_space_in || rx_full); // [RULE16]
	assign rx_kept  = rx_msg_store_in && !rx_lost;
	assign rx_freed = rx_slot_free_cmd && (rx_count != {CNT_W{1'b0}});

	always @*
	begin
		next_rx_count = rx_count;
		if (rx_kept && !rx_freed)
			next_rx_count = rx_count + {{(CNT_W-1){1'b0}}, 1'b1};
		else if (rx_freed && !rx_kept)
			next_rx_count = rx_count - {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE5]
	end

	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			rx_count                <= {CNT_W{1'b0}};
			rx_msg_pending_flag_out <= `CCS_RST_FLAG_ZERO;
			rx_release_out          <= 1'b0;
			rx_irq_clear_out        <= 1'b0;
			rx_ind_out              <= 1'b0;
			relay_go_out            <= 1'b0;
		end
		else
		begin
			rx_count                <= next_rx_count;
			rx_msg_pending_flag_out <= (next_rx_count != {CNT_W{1'b0}}); // [RULE17]
			rx_release_out          <= rx_freed; // [RULE5]
			rx_irq_clear_out        <= rx_freed && (next_rx_count == {CNT_W{1'b0}}); // [RULE5]
			rx_ind_out              <= rx_kept; // [RULE3]
			// The head frame must carry the relay flag as well as the command. [RULE1]
			relay_go_out <= relay_go_cmd && rx_head_relay_in && (rx_count != {CNT_W{1'b0}});
		end
	end

	// Overrun is sticky; a loss in the clearing cycle keeps it set. [RULE16] [RULE4]
	ccs_flag
	#(
		.RESET_VAL (`CCS_RST_FLAG_ZERO)
	)
	u_rx_overflow
	(
		.clock_in (clock_in),
		.reset_in (reset_in),
		.set_in   (rx_lost),
		.clear_in (overflow_clear_cmd),
		.flag_out (rx_overflow_flag_out)
	);

	// Core state is sampled into flops so every status output is registered.
	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			bus_off_flag_out    <= `CCS_RST_FLAG_ZERO;
			error_warn_flag_out <= `CCS_RST_FLAG_ZERO;
			tx_active_flag_out  <= `CCS_RST_FLAG_ZERO;
			rx_active_flag_out  <= `CCS_RST_FLAG_ZERO;
		end
		else
		begin
			bus_off_flag_out    <= core_bus_off_in; // [RULE10]
			error_warn_flag_out <= (tx_err_count_in >= warn_limit_in) ||
				(rx_err_count_in >= warn_limit_in); // [RULE11]
			tx_active_flag_out  <= core_tx_busy_in; // [RULE12]
			rx_active_flag_out  <= core_rx_busy_in; // [RULE13]
		end
	end

	assign state_reg[`CCS_ST_RX_PENDING]  = rx_msg_pending_flag_out;
	assign state_reg[`CCS_ST_RX_OVERFLOW] = rx_overflow_flag_out;
	assign state_reg[`CCS_ST_TX_BUF_FREE] = tx_buffer_free_flag_out;
	assign state_reg[`CCS_ST_TX_DONE]     = tx_done_flag_out;
	assign state_reg[`CCS_ST_RX_ACTIVE]   = rx_active_flag_out;
	assign state_reg[`CCS_ST_TX_ACTIVE]   = tx_active_flag_out;
	assign state_reg[`CCS_ST_ERROR_WARN]  = error_warn_flag_out;
	assign state_reg[`CCS_ST_BUS_OFF]     = bus_off_flag_out;

	// The command register always reads zero; unmapped addresses read zero too.
	always @(posedge clock_in)
	begin
		if (reset_in)
			rdata_out <= `CCS_READ_ZERO;
		else if (rd_in && (addr_in == `CCS_STATE_ADDR))
			rdata_out <= state_reg;
		else
			rdata_out <= `CCS_READ_ZERO; // [RULE18]
	end

endmodule

/* hdl/ccs_defs.vh */
// Register offsets, bit positions and reset values of the CAN command and status block.
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

`define CCS_ADDR_W            12
`define CCS_CMD_ADDR          12'hB01
`define CCS_STATE_ADDR        12'hB02

`define CCS_CMD_SEND_GO       0
`define CCS_CMD_ABORT_SEND    1
`define CCS_CMD_RX_SLOT_FREE  2
`define CCS_CMD_OVF_CLEAR     3
`define CCS_CMD_LOOPBACK_SEND 4
`define CCS_CMD_OVERLOAD_SEND 5
`define CCS_CMD_RELAY_GO      6

`define CCS_ST_RX_PENDING     0
`define CCS_ST_RX_OVERFLOW    1
`define CCS_ST_TX_BUF_FREE    2
`define CCS_ST_TX_DONE        3
`define CCS_ST_RX_ACTIVE      4
`define CCS_ST_TX_ACTIVE      5
`define CCS_ST_ERROR_WARN     6
`define CCS_ST_BUS_OFF        7

`define CCS_RST_TX_DONE       1'b1
`define CCS_RST_TX_BUF_FREE   1'b1
`define CCS_RST_FLAG_ZERO     1'b0
`define CCS_READ_ZERO         8'h00

`endif

/* hdl/ccs_flag.v */
// Sticky status flag whose set takes priority over a simultaneous clear.
`timescale 1ns/10ps
module ccs_flag
#(
	parameter RESET_VAL = 1'b0
)
(
	input  wire clock_in,
	input  wire reset_in,
	input  wire set_in,
	input  wire clear_in,
	output reg  flag_out
);

	always @(posedge clock_in)
	begin
		if (reset_in)
			flag_out <= RESET_VAL;
		else if (set_in)
			flag_out <= 1'b1;
		else if (clear_in)
			flag_out <= 1'b0;
	end

endmodule
